// ### btg_pkg.sv
// Constants and types shared by the tone generator and its envelope unit
// Function
// R1: After reset both shared pins act as plain output ports and carry no tone.
// R2: Setting the true pin select puts the true tone on pin one instead of port data.
// R3: Setting the inverted pin select puts the complementary tone on pin zero.
// R4: Software keeps each pin's port data at 1 and its hi-z control at 0 before tone use.
// R5: With the enable high the tones run; with it low true sits high and inverted low.
// R6: Enable changes are not aligned to the tone, so switch-on and switch-off may glitch.
// R7: The tone is a division of the low-speed oscillator set by a 3-bit frequency field.
// R8: Codes 0 to 7 give 4096.0, 3276.8, 2730.7, 2340.6, 2048.0, 1638.4, 1365.3, 1170.3 Hz.
// R9: A 3-bit duty field sets the level, code 0 loudest (level 1) and code 7 quietest.
// R10: For the 16 and 20 step periods level n gives (9-n)/16 and (9-n)/20 duty.
// R11: For the 24 and 28 step periods level n gives (13-n)/24 and (13-n)/28 duty.
// R12: Duty is low time over period for negative polarity, high time for positive.
// R13: While the envelope is active the duty field is ignored and the envelope sets duty.
// R14: The envelope starts at level 1 on output start, steps to level 8, holds, and restarts.
// R15: Each envelope step lasts 62.5 ms with the step time select at 0 and 125 ms at 1.
// R16: While enabled and routed, the inverted tone is always the complement of the true tone.
// R17: Frequency and duty changes take effect only at the next tone period boundary.
package btg_pkg;

	// Clock rate
	localparam int CLK_MHZ = 100;

	// Envelope step times in microseconds and in clock cycles
	localparam int ENV_STEP_SHORT_US = 62500;
	localparam int ENV_STEP_LONG_US  = 125000;
	localparam int ENV_STEP_SHORT_CYC = ENV_STEP_SHORT_US * CLK_MHZ;
	localparam int ENV_STEP_LONG_CYC  = ENV_STEP_LONG_US * CLK_MHZ;
	localparam int ENV_CNT_W = 24;

	// Tone period in half oscillator cycles, short divider group
	localparam logic [6:0] PER_TICKS_16 = 7'h10;
	localparam logic [6:0] PER_TICKS_20 = 7'h14;
	localparam logic [6:0] PER_TICKS_24 = 7'h18;
	localparam logic [6:0] PER_TICKS_28 = 7'h1c;

	// Low time at level 1 for the two period families
	localparam logic [3:0] DUTY_TOP_SMALL = 4'h8;
	localparam logic [3:0] DUTY_TOP_LARGE = 4'hc;

	// Field positions of the frequency select
	localparam int FREQ_HALF_BIT  = 2;
	localparam int FREQ_LARGE_BIT = 1;

	// Level range and reset values
	localparam logic [2:0] LEVEL_FIRST  = 3'h0;
	localparam logic [2:0] LEVEL_LAST   = 3'h7;
	localparam logic       PIN_OUT_RST  = 1'b1;
	localparam logic       PIN_OE_RST   = 1'b1;
	localparam logic       TRUE_IDLE    = 1'b1;
	localparam logic       INV_IDLE     = 1'b0;

	typedef enum logic [1:0] {
		ENV_IDLE  = 2'b00,
		ENV_DECAY = 2'b01,
		ENV_HOLD  = 2'b10
	} btg_env_state_t;

endpackage

// ### btg_envelope.sv
// Digital envelope: steps the duty level from loudest to quietest
`timescale 1ns/10ps
module btg_envelope
	import btg_pkg::*;
#(
	parameter int STEP_SHORT_CYC = ENV_STEP_SHORT_CYC,
	parameter int STEP_LONG_CYC  = ENV_STEP_LONG_CYC
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       ce,
	input  wire logic       env_on,
	input  wire logic       tone_enable,
	input  wire logic       restart,
	input  wire logic       long_sel,
	output logic            active,
	output logic [2:0]      level
);

	typedef struct packed {
		btg_env_state_t         state;
		logic [ENV_CNT_W-1:0]   cnt;
		logic [2:0]             level;
		logic                   active;
	} btg_env_t;

	localparam logic [ENV_CNT_W-1:0] LAST_SHORT = ENV_CNT_W'(STEP_SHORT_CYC - 1);
	localparam logic [ENV_CNT_W-1:0] LAST_LONG  = ENV_CNT_W'(STEP_LONG_CYC - 1);

	btg_env_t s_reg;
	btg_env_t s_next;
	logic [ENV_CNT_W-1:0] last_cnt;

	always_comb begin
		s_next = s_reg;
		// Step length select
		// R15: step time choice
		last_cnt = long_sel ? LAST_LONG : LAST_SHORT;
		case (s_reg.state)
			ENV_IDLE: begin
				// R14: start at level 1
				if (env_on && tone_enable) begin
					s_next.state = ENV_DECAY;
					s_next.cnt = '0;
					s_next.level = LEVEL_FIRST;
				end
			end
			ENV_DECAY: begin
				if (s_reg.cnt >= last_cnt) begin
					s_next.cnt = '0;
					s_next.level = s_reg.level + 3'h1;
					// R14: hold at level 8
					if (s_reg.level == LEVEL_LAST - 3'h1) begin
						s_next.state = ENV_HOLD;
					end
				end else begin
					s_next.cnt = s_reg.cnt + ENV_CNT_W'(1);
				end
			end
			ENV_HOLD: begin
				s_next.cnt = '0;
			end
			default: begin
				s_next.state = ENV_IDLE;
			end
		endcase
		// R14: restart returns to level 1
		if (s_reg.state != ENV_IDLE && restart) begin
			s_next.state = ENV_DECAY;
			s_next.cnt = '0;
			s_next.level = LEVEL_FIRST;
		end
		if (!env_on || !tone_enable) begin
			s_next.state = ENV_IDLE;
			s_next.cnt = '0;
		end
		s_next.active = (s_next.state != ENV_IDLE);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_reg <= '{state: ENV_IDLE, cnt: '0, level: LEVEL_FIRST, active: 1'b0};
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign active = s_reg.active;
	assign level = s_reg.level;

endmodule // btg_envelope

// ### btg_tone_gen.sv
// Tone generator top: divider, duty shaping and shared pin routing
`timescale 1ns/10ps
module btg_tone_gen
	import btg_pkg::*;
#(
	parameter int ENV_STEP_SHORT = ENV_STEP_SHORT_CYC,
	parameter int ENV_STEP_LONG  = ENV_STEP_LONG_CYC
) (
	input  wire logic       CLK,
	input  wire logic       RESET,
	input  wire logic       CE,
	input  wire logic       LOW_SPEED_OSC,
	input  wire logic       TONE_OUTPUT_ENABLE,
	input  wire logic [2:0] TONE_FREQ_SELECT,
	input  wire logic [2:0] TONE_DUTY_SELECT,
	input  wire logic       ENVELOPE_ON,
	input  wire logic       ENVELOPE_RESTART,
	input  wire logic       ENVELOPE_STEP_TIME_SELECT,
	input  wire logic       TRUE_TONE_PIN_SELECT,
	input  wire logic       INVERTED_TONE_PIN_SELECT,
	input  wire logic       PORT_PIN_ONE_DATA,
	input  wire logic       PORT_PIN_ZERO_DATA,
	input  wire logic       PIN_ONE_HIZ_CTRL,
	input  wire logic       PIN_ZERO_HIZ_CTRL,
	output logic            PORT_PIN_ONE_OUT,
	output logic            PORT_PIN_ONE_OE,
	output logic            PORT_PIN_ZERO_OUT,
	output logic            PORT_PIN_ZERO_OE,
	output logic            TONE_OUT_TRUE,
	output logic            TONE_OUT_INVERTED,
	output logic [2:0]      TONE_LEVEL,
	output logic            ENVELOPE_ACTIVE
);

	typedef struct packed {
		logic       osc_prev;
		logic [6:0] phase;
		logic [6:0] period;
		logic [6:0] low_len;
		logic [2:0] level;
		logic       env_active;
		logic       tone_true;
		logic       tone_inv;
		logic       pin_one_out;
		logic       pin_one_oe;
		logic       pin_zero_out;
		logic       pin_zero_oe;
	} btg_top_t;

	btg_top_t s_reg;
	btg_top_t s_next;

	logic       env_active;
	logic [2:0] env_level;
	logic       half_tick;
	logic       period_end;
	logic [2:0] duty_code;
	logic [6:0] new_period;
	logic [6:0] new_low;
	logic       wave_true;

	// Period in half oscillator cycles for a frequency code
	function automatic logic [6:0] period_of(input logic [2:0] freq);
		logic [6:0] base;
		base = PER_TICKS_16;
		case (freq[1:0])
			2'b00: base = PER_TICKS_16;
			2'b01: base = PER_TICKS_20;
			2'b10: base = PER_TICKS_24;
			2'b11: base = PER_TICKS_28;
			default: base = PER_TICKS_16;
		endcase
		if (freq[FREQ_HALF_BIT]) begin
			base = {base[5:0], 1'b0};
		end
		return base;
	endfunction

	// Low time in half oscillator cycles for frequency and level
	function automatic logic [6:0] low_of(input logic [2:0] freq,
			input logic [2:0] lvl);
		logic [3:0] top;
		logic [3:0] num;
		logic [6:0] len;
		top = DUTY_TOP_SMALL;
		if (freq[FREQ_LARGE_BIT]) begin
			top = DUTY_TOP_LARGE;
		end
		num = top - {1'b0, lvl};
		len = {3'b000, num};
		if (freq[FREQ_HALF_BIT]) begin
			len = {len[5:0], 1'b0};
		end
		return len;
	endfunction

	btg_envelope #(
		.STEP_SHORT_CYC (ENV_STEP_SHORT),
		.STEP_LONG_CYC  (ENV_STEP_LONG)
	) u_envelope (
		.clk         (CLK),
		.reset       (RESET),
		.ce          (CE),
		.env_on      (ENVELOPE_ON),
		.tone_enable (TONE_OUTPUT_ENABLE),
		.restart     (ENVELOPE_RESTART),
		.long_sel    (ENVELOPE_STEP_TIME_SELECT),
		.active      (env_active),
		.level       (env_level)
	);

	always_comb begin
		s_next = s_reg;

		// Both oscillator edges give the half-cycle tick
		// R7: divide the low-speed oscillator
		s_next.osc_prev = LOW_SPEED_OSC;
		half_tick = LOW_SPEED_OSC ^ s_reg.osc_prev;
		period_end = half_tick && (s_reg.phase >= s_reg.period - 7'h01);

		// Envelope overrides the duty field
		// R13: envelope owns the duty
		duty_code = env_active ? env_level : TONE_DUTY_SELECT;

		// R8: period per frequency code
		new_period = period_of(TONE_FREQ_SELECT);
		// R10: short families
		// R11: long families
		new_low = low_of(TONE_FREQ_SELECT, duty_code);

		// Settings are taken only at the period boundary
		if (half_tick) begin
			if (period_end) begin
				s_next.phase = '0;
				// R17: latch at boundary
				s_next.period = new_period;
				s_next.low_len = new_low;
				s_next.level = duty_code;
				s_next.env_active = env_active;
			end else begin
				s_next.phase = s_reg.phase + 7'h01;
			end
		end

		// Negative polarity: low for the duty part of the period
		// R12: low time is the duty
		// R9: level sets low time
		wave_true = (s_reg.phase >= s_reg.low_len);

		// Enable gates the waveform directly, unaligned
		// R6: no alignment to the tone
		// R5: idle true high, inverted low
		if (TONE_OUTPUT_ENABLE) begin
			s_next.tone_true = wave_true;
			// R16: exact complement
			s_next.tone_inv = ~wave_true;
		end else begin
			s_next.tone_true = TRUE_IDLE;
			s_next.tone_inv = INV_IDLE;
		end

		// Pin one: port data or true tone
		// R2: true tone routing
		if (TRUE_TONE_PIN_SELECT) begin
			s_next.pin_one_out = s_next.tone_true;
		end else begin
			s_next.pin_one_out = PORT_PIN_ONE_DATA;
		end
		s_next.pin_one_oe = ~PIN_ONE_HIZ_CTRL;

		// Pin zero: port data or inverted tone
		// R3: inverted tone routing
		if (INVERTED_TONE_PIN_SELECT) begin
			s_next.pin_zero_out = s_next.tone_inv;
		end else begin
			s_next.pin_zero_out = PORT_PIN_ZERO_DATA;
		end
		s_next.pin_zero_oe = ~PIN_ZERO_HIZ_CTRL;
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			// R1: pins start as plain ports
			s_reg <= '{
				osc_prev:     LOW_SPEED_OSC,
				phase:        '0,
				period:       PER_TICKS_16,
				low_len:      {3'b000, DUTY_TOP_SMALL},
				level:        LEVEL_FIRST,
				env_active:   1'b0,
				tone_true:    TRUE_IDLE,
				tone_inv:     INV_IDLE,
				pin_one_out:  PIN_OUT_RST,
				pin_one_oe:   PIN_OE_RST,
				pin_zero_out: PIN_OUT_RST,
				pin_zero_oe:  PIN_OE_RST
			};
		end else if (CE) begin
			s_reg <= s_next;
		end
	end

	assign PORT_PIN_ONE_OUT = s_reg.pin_one_out;
	assign PORT_PIN_ONE_OE = s_reg.pin_one_oe;
	assign PORT_PIN_ZERO_OUT = s_reg.pin_zero_out;
	assign PORT_PIN_ZERO_OE = s_reg.pin_zero_oe;
	assign TONE_OUT_TRUE = s_reg.tone_true;
	assign TONE_OUT_INVERTED = s_reg.tone_inv;
	assign TONE_LEVEL = s_reg.level;
	assign ENVELOPE_ACTIVE = s_reg.env_active;

endmodule // btg_tone_gen

// ### btg_tone_gen_properties.sv
// Concurrent checks on the tone generator ports
`timescale 1ns/10ps
module btg_tone_gen_properties (
	input wire logic       CLK,
	input wire logic       RESET,
	input wire logic       CE,
	input wire logic       TONE_OUTPUT_ENABLE,
	input wire logic       TRUE_TONE_PIN_SELECT,
	input wire logic       INVERTED_TONE_PIN_SELECT,
	input wire logic       PORT_PIN_ONE_DATA,
	input wire logic       PORT_PIN_ZERO_DATA,
	input wire logic       PIN_ONE_HIZ_CTRL,
	input wire logic       PORT_PIN_ONE_OUT,
	input wire logic       PORT_PIN_ONE_OE,
	input wire logic       PORT_PIN_ZERO_OUT,
	input wire logic       TONE_OUT_TRUE,
	input wire logic       TONE_OUT_INVERTED,
	input wire logic [2:0] TONE_LEVEL,
	input wire logic       ENVELOPE_ACTIVE
);
	// Longest low run: 24 ticks of 4 clocks at the bench rate
	localparam int LOW_MAX = 96;
	int low_run_reg;
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	always_ff @(posedge CLK) begin
		if (RESET || !TONE_OUTPUT_ENABLE || TONE_OUT_TRUE) low_run_reg <= 0;
		else if (CE) low_run_reg <= low_run_reg + 1;
	end
	idle_levels_a: assert property (!TONE_OUTPUT_ENABLE |=> TONE_OUT_TRUE && !TONE_OUT_INVERTED)
		else $error("tone not idle while disabled");
	tone_complement_a: assert property (TONE_OUT_INVERTED == !TONE_OUT_TRUE)
		else $error("inverted tone not complement");
	pin_one_tone_a: assert property (TRUE_TONE_PIN_SELECT |=> PORT_PIN_ONE_OUT == TONE_OUT_TRUE)
		else $error("pin one not carrying true tone");
	pin_zero_tone_a: assert property (INVERTED_TONE_PIN_SELECT |=> PORT_PIN_ZERO_OUT == TONE_OUT_INVERTED)
		else $error("pin zero not carrying inverted tone");
	port_data_a: assert property (!TRUE_TONE_PIN_SELECT && !INVERTED_TONE_PIN_SELECT |=>
		PORT_PIN_ONE_OUT == $past(PORT_PIN_ONE_DATA) && PORT_PIN_ZERO_OUT == $past(PORT_PIN_ZERO_DATA))
		else $error("port data not on pins");
	pin_release_a: assert property (1'h1 |=> PORT_PIN_ONE_OE == !$past(PIN_ONE_HIZ_CTRL))
		else $error("pin one enable wrong");
	low_cap_a: assert property (low_run_reg <= LOW_MAX)
		else $error("low time too long");
	env_step_a: assert property (ENVELOPE_ACTIVE && $past(ENVELOPE_ACTIVE) && TONE_LEVEL != $past(TONE_LEVEL)
		|-> TONE_LEVEL == 3'($past(TONE_LEVEL) + 3'h1) || TONE_LEVEL == 3'h0)
		else $error("envelope level skipped");
	cover property (ENVELOPE_ACTIVE && TONE_LEVEL == 3'h7);
	cover property ($rose(TONE_OUT_TRUE) && TRUE_TONE_PIN_SELECT);
	cover property ($fell(PORT_PIN_ONE_OUT) && !TRUE_TONE_PIN_SELECT);
endmodule // btg_tone_gen_properties
bind btg_tone_gen btg_tone_gen_properties u_props (.CLK(CLK), .RESET(RESET), .CE(CE),
	.TONE_OUTPUT_ENABLE(TONE_OUTPUT_ENABLE), .TRUE_TONE_PIN_SELECT(TRUE_TONE_PIN_SELECT),
	.INVERTED_TONE_PIN_SELECT(INVERTED_TONE_PIN_SELECT), .PORT_PIN_ONE_DATA(PORT_PIN_ONE_DATA),
	.PORT_PIN_ZERO_DATA(PORT_PIN_ZERO_DATA), .PIN_ONE_HIZ_CTRL(PIN_ONE_HIZ_CTRL),
	.PORT_PIN_ONE_OUT(PORT_PIN_ONE_OUT), .PORT_PIN_ONE_OE(PORT_PIN_ONE_OE),
	.PORT_PIN_ZERO_OUT(PORT_PIN_ZERO_OUT), .TONE_OUT_TRUE(TONE_OUT_TRUE),
	.TONE_OUT_INVERTED(TONE_OUT_INVERTED), .TONE_LEVEL(TONE_LEVEL),
	.ENVELOPE_ACTIVE(ENVELOPE_ACTIVE));

// ### btg_buzzer_model.sv
// Piezo buzzer model: measures low time and period seen on pin one
`timescale 1ns/10ps
module btg_buzzer_model (
	input wire logic        clk,
	input wire logic        pin_one,
	output logic     [15:0] low_len,
	output logic     [15:0] per_len
);
	logic [15:0] low_cnt;
	logic [15:0] per_cnt;
	logic        last;
	initial begin
		low_cnt = 16'h0000;
		per_cnt = 16'h0000;
		low_len = 16'h0000;
		per_len = 16'h0000;
		last = 1'h1;
	end
	always @(posedge clk) begin
		per_cnt <= per_cnt + 16'h0001;
		if (!pin_one) low_cnt <= low_cnt + 16'h0001;
		if (last && !pin_one) begin
			per_len <= per_cnt;
			per_cnt <= 16'h0001;
			low_cnt <= 16'h0001;
		end
		if (!last && pin_one) low_len <= low_cnt;
		last <= pin_one;
	end
endmodule // btg_buzzer_model

// ### btg_tone_gen_tb.sv
// Self-checking bench for the tone generator
`timescale 1ns/10ps
module btg_tone_gen_tb;
	logic        clk, reset, osc, en, env_on, env_rst, env_long, sel_t, sel_i, ce;
	logic        d1, d0, hiz1, hiz0, p1_out, p1_oe, p0_out, p0_oe, t_true, t_inv, env_act;
	logic [2:0]  freq, duty, level;
	logic [15:0] low_len, per_len;
	int          err_total, compares;
	int          per_t[4] = '{16, 20, 24, 28};
	btg_tone_gen #(.ENV_STEP_SHORT(300), .ENV_STEP_LONG(600)) u_dut (.CLK(clk), .RESET(reset),
		.CE(ce), .LOW_SPEED_OSC(osc), .TONE_OUTPUT_ENABLE(en), .TONE_FREQ_SELECT(freq),
		.TONE_DUTY_SELECT(duty), .ENVELOPE_ON(env_on), .ENVELOPE_RESTART(env_rst),
		.ENVELOPE_STEP_TIME_SELECT(env_long), .TRUE_TONE_PIN_SELECT(sel_t),
		.INVERTED_TONE_PIN_SELECT(sel_i), .PORT_PIN_ONE_DATA(d1), .PORT_PIN_ZERO_DATA(d0),
		.PIN_ONE_HIZ_CTRL(hiz1), .PIN_ZERO_HIZ_CTRL(hiz0), .PORT_PIN_ONE_OUT(p1_out),
		.PORT_PIN_ONE_OE(p1_oe), .PORT_PIN_ZERO_OUT(p0_out), .PORT_PIN_ZERO_OE(p0_oe),
		.TONE_OUT_TRUE(t_true), .TONE_OUT_INVERTED(t_inv), .TONE_LEVEL(level),
		.ENVELOPE_ACTIVE(env_act));
	// Released pin is pulled high
	btg_buzzer_model u_buzzer (.clk(clk), .pin_one(p1_oe ? p1_out : 1'h1), .low_len(low_len),
		.per_len(per_len));
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// Oscillator half cycle every 4 clocks
	initial begin
		osc = 1'h0;
		forever begin
			repeat (4) @(negedge clk);
			osc = ~osc;
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		cyc(20000);
		err_total++;
		end_of_test();
	end
	initial begin
		{en, env_on, env_rst, env_long, sel_t, sel_i, hiz1, hiz0} = 8'h00;
		{d1, d0} = 2'h3;
		ce = 1'h1;
		freq = 3'h0;
		duty = 3'h0;
		reset = 1'h1;
		cyc(6);
		reset = 1'h0;
		cyc(2);
		chk("tone_true", 16'h1, t_true);
		chk("pin_one_out", 16'h1, p1_out);
		chk("pin_one_oe", 16'h1, p1_oe);
		d1 = 1'h0;
		hiz0 = 1'h1;
		cyc(2);
		chk("pin_one_data", 16'h0, p1_out);
		chk("pin_zero_oe", 16'h0, p0_oe);
		// Pins prepared for tone use
		d1 = 1'h1;
		hiz0 = 1'h0;
		sel_t = 1'h1;
		sel_i = 1'h1;
		en = 1'h1;
		for (int f = 0; f < 8; f++) begin
			freq = 3'(f);
			duty = 3'(f);
			cyc(700);
			chk("period", 16'(per_t[f % 4] * (f[2] ? 8 : 4)), per_len);
			chk("low_time", 16'(((f[1] ? 12 : 8) - f) * (f[2] ? 8 : 4)), low_len);
			chk("level", 16'(f), level);
		end
		en = 1'h0;
		cyc(2);
		chk("idle_true", 16'h1, p1_out);
		chk("idle_inv", 16'h0, p0_out);
		chk("idle_inv_tone", 16'h0, t_inv);
		freq = 3'h0;
		duty = 3'h3;
		env_on = 1'h1;
		en = 1'h1;
		cyc(150);
		chk("env_active", 16'h1, env_act);
		chk("env_first", 16'h0, level);
		cyc(2600);
		chk("env_hold", 16'h7, level);
		env_long = 1'h1;
		env_rst = 1'h1;
		cyc(1);
		env_rst = 1'h0;
		cyc(450);
		chk("env_long_wait", 16'h0, level);
		// Clock enable low freezes envelope and tone
		ce = 1'h0;
		cyc(300);
		chk("ce_freeze", 16'h0, level);
		cyc(300);
		ce = 1'h1;
		cyc(300);
		chk("env_long_step", 16'h1, level);
		env_on = 1'h0;
		cyc(150);
		chk("env_off", 16'h0, env_act);
		chk("duty_back", 16'h3, level);
		end_of_test();
	end
endmodule // btg_tone_gen_tb
